// ### design/temp_cfg_regs.svh
`ifndef TEMP_CFG_REGS_SVH
`define TEMP_CFG_REGS_SVH

// Register word offsets on the register port
`define ZONE_ACTION_OFFSET    8'h0C
`define PROTECT_SET_OFFSET    8'h0D

// temp_zone_charge_action fields
`define WARM_SEL_MSB          14
`define WARM_SEL_LSB          13
`define COOL_SEL_MSB          12
`define COOL_SEL_LSB          11
`define VDEC_MSB              10
`define VDEC_LSB              6
`define ISCALE_MSB            5
`define ISCALE_LSB            4

// temp_protect_setting fields
`define EXT_EN_BIT            15
`define EXT_ACT_BIT           13
`define EXT_THR_MSB           12
`define EXT_THR_LSB           10
`define THERM_EN_BIT          9
`define THERM_RSP_BIT         8

// Reset values
`define WARM_SEL_RST          2'h1
`define COOL_SEL_RST          2'h2
`define VDEC_RST              5'h10
`define ISCALE_RST            2'h1
`define EXT_EN_RST            1'h1
`define EXT_THR_RST           3'h4
`define THERM_EN_RST          1'h1

// Decrement step in mV per cell
`define VDEC_STEP_MV          16'h0014

`endif

// ### design/temp_cfg_pkg.sv
package temp_cfg_pkg;

   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_VOLT = 2'h1,
      ACT_CURR = 2'h2,
      ACT_BOTH = 2'h3
   } zone_action_t;

   typedef struct packed {
      zone_action_t warm_response_select;
      zone_action_t cool_response_select;
      logic [4:0]   full_voltage_decrement;
      logic [1:0]   cc_current_scale;
      logic         ext_sensor_enable;
      logic         ext_overtemp_response;
      logic [2:0]   ext_overtemp_threshold;
      logic         thermistor_protect_enable;
      logic         thermistor_response;
   } cfg_t;

endpackage

// ### design/charge_target_calc.sv
`timescale 1ns/1ps
`include "temp_cfg_regs.svh"

module charge_target_calc (
   input  wire logic [15:0] battery_full_voltage,
   input  wire logic [15:0] cc_current_set,
   input  wire logic [1:0]  cell_count,
   input  wire logic [4:0]  full_voltage_decrement,
   input  wire logic [1:0]  cc_current_scale,
   input  wire logic        reduce_volt,
   input  wire logic        reduce_curr,
   output logic      [15:0] target_mv,
   output logic      [15:0] cc_eff_ma
);
   logic [15:0] dec_mv;
   logic [15:0] total_mv;
   logic [4:0]  shift;

   always_comb begin
      dec_mv   = 16'({11'h000, full_voltage_decrement} * `VDEC_STEP_MV);
      total_mv = 16'(dec_mv * {14'h0000, cell_count + 2'h0} + dec_mv);
      // Clamp at zero rather than wrap on a tiny programmed voltage
      if (!reduce_volt) begin
         target_mv = battery_full_voltage;
      end else if (total_mv > battery_full_voltage) begin
         target_mv = 16'h0000;
      end else begin
         target_mv = 16'(battery_full_voltage - total_mv);
      end
      shift = {3'h0, cc_current_scale} + 5'h01;
      if (reduce_curr) begin
         cc_eff_ma = cc_current_set >> shift;
      end else begin
         cc_eff_ma = cc_current_set;
      end
   end
endmodule

// ### design/battery_temp_action_config.sv
// Behaviour
// - Warm response picks none, voltage, current or both, reset 01.
// - Cool response uses the same encoding in the cool zone, reset 10.
// - Decrement lowers full voltage 20 mV per cell per step, reset 320 mV.
// - Current scale divides charge current by 2, 4, 8 or 16, reset 01.
// - External sensor enable turns hot-spot sensing on or off, reset on.
// - External over-temperature interrupts, input regulation if response 1.
// - Power-up external response bit value loads from one-time memory.
// - Three-bit external threshold selects eight points, reset 100.
// - Thermistor protect enable turns zone protection on or off, reset on.
// - Any thermistor zone interrupts; reductions only when response is 1.
`timescale 1ns/1ps
`include "temp_cfg_regs.svh"

module battery_temp_action_config (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       wdt_reset,
   input  wire logic                       otp_ext_response,
   input  wire logic                       otp_ntc_response,
   input  wire logic                       reg_wr_en,
   input  wire logic                       reg_rd_en,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [15:0]                reg_wr_data,
   output logic      [15:0]                reg_rd_data,
   input  wire logic                       zone_warm_raw,
   input  wire logic                       zone_cool_raw,
   input  wire logic                       zone_hot_raw,
   input  wire logic                       zone_cold_raw,
   input  wire logic                       ext_overtemp_raw,
   input  wire logic [15:0]                battery_full_voltage,
   input  wire logic [15:0]                cc_current_set,
   input  wire logic [1:0]                 cell_count,
   output temp_cfg_pkg::cfg_t              cfg,
   output logic                            int_pulse,
   output logic                            iin_regulate,
   output logic                            volt_reduce,
   output logic                            curr_reduce,
   output logic      [15:0]                full_target_mv,
   output logic      [15:0]                cc_target_ma
);
   import temp_cfg_pkg::*;

   localparam int NZ = 5;

   typedef struct packed {
      cfg_t            cfg;
      logic [NZ-1:0]   sync1;
      logic [NZ-1:0]   sync2;
      logic [NZ-1:0]   prev;
      logic [15:0]     rd_data;
      logic            irq;
      logic            iin_reg;
      logic            vred;
      logic            cred;
      logic [15:0]     vtarget;
      logic [15:0]     itarget;
   } state_t;

   state_t      st_ff;
   state_t      nxt_st;
   logic [15:0] calc_v;
   logic [15:0] calc_i;
   logic        want_v;
   logic        want_i;
   logic [NZ-1:0] raw_zone;
   logic [NZ-1:0] rise;

   function automatic logic act_volt(input zone_action_t a);
      act_volt = (a == ACT_VOLT) || (a == ACT_BOTH);
   endfunction

   function automatic logic act_curr(input zone_action_t a);
      act_curr = (a == ACT_CURR) || (a == ACT_BOTH);
   endfunction

   function automatic logic [15:0] pack_action(input cfg_t c);
      pack_action = 16'h0000;
      pack_action[`WARM_SEL_MSB:`WARM_SEL_LSB] = c.warm_response_select;
      pack_action[`COOL_SEL_MSB:`COOL_SEL_LSB] = c.cool_response_select;
      pack_action[`VDEC_MSB:`VDEC_LSB]         = c.full_voltage_decrement;
      pack_action[`ISCALE_MSB:`ISCALE_LSB]     = c.cc_current_scale;
   endfunction

   function automatic logic [15:0] pack_protect(input cfg_t c);
      pack_protect = 16'h0000;
      pack_protect[`EXT_EN_BIT]                = c.ext_sensor_enable;
      pack_protect[`EXT_ACT_BIT]               = c.ext_overtemp_response;
      pack_protect[`EXT_THR_MSB:`EXT_THR_LSB]  = c.ext_overtemp_threshold;
      pack_protect[`THERM_EN_BIT]              = c.thermistor_protect_enable;
      pack_protect[`THERM_RSP_BIT]             = c.thermistor_response;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Zone bits: 0 warm, 1 cool, 2 hot, 3 cold, 4 external hot spot

   assign raw_zone = {ext_overtemp_raw, zone_cold_raw, zone_hot_raw,
                      zone_cool_raw, zone_warm_raw};
   assign rise     = st_ff.sync2 & ~st_ff.prev;

   charge_target_calc charge_target_calc_i (
      .battery_full_voltage   (battery_full_voltage),
      .cc_current_set         (cc_current_set),
      .cell_count             (cell_count),
      .full_voltage_decrement (st_ff.cfg.full_voltage_decrement),
      .cc_current_scale       (st_ff.cfg.cc_current_scale),
      .reduce_volt            (want_v),
      .reduce_curr            (want_i),
      .target_mv              (calc_v),
      .cc_eff_ma              (calc_i)
   );

   ////////////////////////////////////////////////////////////////////////

   // Kept apart from the state block so the target path is not a loop
   always_comb begin
      want_v = 1'b0;
      want_i = 1'b0;

      // Warm wins if comparators ever overlap
      if (st_ff.cfg.thermistor_protect_enable &&
          st_ff.cfg.thermistor_response) begin
         if (st_ff.sync2[0]) begin
            want_v = act_volt(st_ff.cfg.warm_response_select);
            want_i = act_curr(st_ff.cfg.warm_response_select);
         end else if (st_ff.sync2[1]) begin
            want_v = act_volt(st_ff.cfg.cool_response_select);
            want_i = act_curr(st_ff.cfg.cool_response_select);
         end
      end
   end

   always_comb begin
      nxt_st = st_ff;

      nxt_st.sync1 = raw_zone;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.prev  = st_ff.sync2;

      nxt_st.irq = ((|rise[3:0]) &&
                    st_ff.cfg.thermistor_protect_enable) ||
                   (rise[4] && st_ff.cfg.ext_sensor_enable);
      nxt_st.iin_reg = st_ff.sync2[4] && st_ff.cfg.ext_sensor_enable &&
                       st_ff.cfg.ext_overtemp_response;
      nxt_st.vred    = want_v;
      nxt_st.cred    = want_i;
      nxt_st.vtarget = calc_v;
      nxt_st.itarget = calc_i;

      // Reserved bits are not stored and read back as zero
      if (reg_rd_en) begin
         case (reg_addr)
            `ZONE_ACTION_OFFSET: begin
               nxt_st.rd_data = pack_action(st_ff.cfg);
            end
            `PROTECT_SET_OFFSET: begin
               nxt_st.rd_data = pack_protect(st_ff.cfg);
            end
            default: begin
               nxt_st.rd_data = 16'h0000;
            end
         endcase
      end

      if (reg_wr_en) begin
         case (reg_addr)
            `ZONE_ACTION_OFFSET: begin
               nxt_st.cfg.warm_response_select = zone_action_t'(
                  reg_wr_data[`WARM_SEL_MSB:`WARM_SEL_LSB]);
               nxt_st.cfg.cool_response_select = zone_action_t'(
                  reg_wr_data[`COOL_SEL_MSB:`COOL_SEL_LSB]);
               nxt_st.cfg.full_voltage_decrement =
                  reg_wr_data[`VDEC_MSB:`VDEC_LSB];
               nxt_st.cfg.cc_current_scale =
                  reg_wr_data[`ISCALE_MSB:`ISCALE_LSB];
            end
            `PROTECT_SET_OFFSET: begin
               nxt_st.cfg.ext_sensor_enable =
                  reg_wr_data[`EXT_EN_BIT];
               nxt_st.cfg.ext_overtemp_response =
                  reg_wr_data[`EXT_ACT_BIT];
               nxt_st.cfg.ext_overtemp_threshold =
                  reg_wr_data[`EXT_THR_MSB:`EXT_THR_LSB];
               nxt_st.cfg.thermistor_protect_enable =
                  reg_wr_data[`THERM_EN_BIT];
               nxt_st.cfg.thermistor_response =
                  reg_wr_data[`THERM_RSP_BIT];
            end
            default: begin
            end
         endcase
      end

      // Watchdog restores only the fields it owns; it beats a same-cycle write
      if (wdt_reset) begin
         nxt_st.cfg.warm_response_select   = zone_action_t'(`WARM_SEL_RST);
         nxt_st.cfg.cool_response_select   = zone_action_t'(`COOL_SEL_RST);
         nxt_st.cfg.full_voltage_decrement = `VDEC_RST;
         nxt_st.cfg.cc_current_scale       = `ISCALE_RST;
         nxt_st.cfg.ext_overtemp_response  = otp_ext_response;
      end

      if (rst) begin
         nxt_st = '0;
         nxt_st.cfg.warm_response_select      = zone_action_t'(`WARM_SEL_RST);
         nxt_st.cfg.cool_response_select      = zone_action_t'(`COOL_SEL_RST);
         nxt_st.cfg.full_voltage_decrement    = `VDEC_RST;
         nxt_st.cfg.cc_current_scale          = `ISCALE_RST;
         nxt_st.cfg.ext_sensor_enable         = `EXT_EN_RST;
         // Synchronous reset, so the one-time memory level may load here
         nxt_st.cfg.ext_overtemp_response     = otp_ext_response;
         nxt_st.cfg.ext_overtemp_threshold    = `EXT_THR_RST;
         nxt_st.cfg.thermistor_protect_enable = `THERM_EN_RST;
         nxt_st.cfg.thermistor_response       = otp_ntc_response;
      end
   end

   always_ff @(posedge core_clk) begin
      st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////

   assign reg_rd_data    = st_ff.rd_data;
   assign cfg            = st_ff.cfg;
   assign int_pulse      = st_ff.irq;
   assign iin_regulate   = st_ff.iin_reg;
   assign volt_reduce    = st_ff.vred;
   assign curr_reduce    = st_ff.cred;
   assign full_target_mv = st_ff.vtarget;
   assign cc_target_ma   = st_ff.itarget;
endmodule

// ### test/battery_temp_action_config_asserts.sv
`timescale 1ns/1ps
module battery_temp_action_config_chk (
   input wire logic               core_clk,
   input wire logic               rst,
   input wire logic               wdt_reset,
   input wire logic               otp_ext_response,
   input wire logic               reg_wr_en,
   input wire logic [7:0]         reg_addr,
   input wire logic [15:0]        reg_wr_data,
   input wire temp_cfg_pkg::cfg_t cfg,
   input wire logic               iin_regulate,
   input wire logic               volt_reduce,
   input wire logic [15:0]        battery_full_voltage,
   input wire logic [1:0]         cell_count,
   input wire logic [15:0]        full_target_mv
);
   import temp_cfg_pkg::*;
   logic        wr_prot;
   logic [17:0] drop;
   logic [15:0] vexp;
   assign wr_prot = reg_wr_en && reg_addr == 8'h0D;
   // Wide enough that 31 steps times 4 cells never wraps
   assign drop = 18'(cfg.full_voltage_decrement) * 18'h14
                 * (18'(cell_count) + 18'h1);
   assign vexp = (drop > 18'(battery_full_voltage)) ? 16'h0000
                 : 16'(18'(battery_full_voltage) - drop);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_warm_cool_rst: assert property ($fell(rst) |->
      cfg.warm_response_select == 2'h1 && cfg.cool_response_select == 2'h2)
      else $error("warm or cool select wrong after reset");
   a_vdec_scale_rst: assert property ($fell(rst) |->
      cfg.full_voltage_decrement == 5'h10 && cfg.cc_current_scale == 2'h1)
      else $error("decrement or scale wrong after reset");
   a_prot_rst: assert property ($fell(rst) |->
      cfg.ext_sensor_enable && cfg.thermistor_protect_enable
      && cfg.ext_overtemp_threshold == 3'h4)
      else $error("protect fields wrong after reset");
   a_wdt_otp_load: assert property (wdt_reset |=>
      cfg.ext_overtemp_response == $past(otp_ext_response)
      && cfg.warm_response_select == 2'h1)
      else $error("watchdog reload wrong");
   a_ext_write: assert property (wr_prot && !wdt_reset |=>
      cfg.ext_sensor_enable == $past(reg_wr_data[15])
      && cfg.ext_overtemp_threshold == $past(reg_wr_data[12:10]))
      else $error("sensor enable or threshold not written");
   a_ntc_write: assert property (wr_prot |=>
      cfg.thermistor_protect_enable == $past(reg_wr_data[9]))
      else $error("thermistor enable not written");
   a_iin_gated: assert property ($rose(iin_regulate) |->
      $past(cfg.ext_sensor_enable && cfg.ext_overtemp_response))
      else $error("input regulation without response bit");
   a_reduce_gated: assert property ($rose(volt_reduce) |->
      $past(cfg.thermistor_protect_enable && cfg.thermistor_response))
      else $error("voltage reduction without response bit");
   a_target_math: assert property (volt_reduce && $past(volt_reduce)
      && $stable(battery_full_voltage) && $stable(cell_count)
      && $stable(cfg.full_voltage_decrement) |-> full_target_mv == vexp)
      else $error("reduced full voltage target wrong");
endmodule
////////////////////////////////////////////////////////////
bind battery_temp_action_config battery_temp_action_config_chk
   battery_temp_action_config_chk_i (.core_clk, .rst, .wdt_reset,
   .otp_ext_response, .reg_wr_en, .reg_addr, .reg_wr_data, .cfg,
   .iin_regulate, .volt_reduce, .battery_full_voltage, .cell_count,
   .full_target_mv);

// ### test/battery_temp_action_config_test.sv
`timescale 1ns/1ps
module battery_temp_action_config_test;
   import temp_cfg_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        wdt_reset = 1'b0;
   logic        otp_ext_response = 1'b1;
   logic        otp_ntc_response = 1'b1;
   logic        reg_wr_en = 1'b0;
   logic        reg_rd_en = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wr_data = 16'h0000;
   logic [15:0] reg_rd_data;
   logic [4:0]  raw = 5'h00;
   logic [15:0] battery_full_voltage = 16'h41A0;
   logic [15:0] cc_current_set = 16'h07D0;
   logic [1:0]  cell_count = 2'h3;
   cfg_t        cfg;
   logic        int_pulse, iin_regulate, volt_reduce, curr_reduce;
   logic [15:0] full_target_mv, cc_target_ma;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;
   battery_temp_action_config battery_temp_action_config_i (
      .core_clk, .rst, .wdt_reset, .otp_ext_response, .otp_ntc_response,
      .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
      .zone_warm_raw(raw[0]), .zone_cool_raw(raw[1]), .zone_hot_raw(raw[2]),
      .zone_cold_raw(raw[3]), .ext_overtemp_raw(raw[4]),
      .battery_full_voltage, .cc_current_set, .cell_count, .cfg, .int_pulse,
      .iin_regulate, .volt_reduce, .curr_reduce, .full_target_mv,
      .cc_target_ma);
   always #2.5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Run is about 250 cycles, so this only trips on a hang
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic e, input logic n);
      @(posedge core_clk);
      rst <= 1'b1;
      otp_ext_response <= e;
      otp_ntc_response <= n;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      #1;
      chk(reg_rd_data, exp);
   endtask
   // Flags are {int, iin, volt, curr}; the interrupt must last one cycle
   task automatic zone(input int b, input logic [3:0] f,
                       input logic [15:0] v, input logic [15:0] c);
      @(posedge core_clk);
      raw[b] <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk({12'h000, int_pulse, iin_regulate, volt_reduce, curr_reduce},
          {12'h000, f});
      chk(full_target_mv, v);
      chk(cc_target_ma, c);
      @(posedge core_clk);
      #1;
      chk({15'h0000, int_pulse}, 16'h0000);
      @(posedge core_clk);
      raw <= 5'h00;
      repeat (4) @(posedge core_clk);
   endtask
   function automatic logic [15:0] tv(int a, int n);
      return a[0] ? 16'h41A0 - 16'(16'h026C * (n + 1)) : 16'h41A0;
   endfunction
   function automatic logic [15:0] tc(int a, int s);
      return a[1] ? 16'h07D0 >> (s + 1) : 16'h07D0;
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b1, 1'b1);
      rdc(8'h0C, 16'h3410);
      rdc(8'h0D, 16'hB300);
      do_reset(1'b0, 1'b0);
      rdc(8'h0D, 16'h9200);
      wr(8'h0C, 16'hFFFF);
      rdc(8'h0C, 16'h7FF0);
      // Reserved bit 14 reads zero, so writing it as zero keeps it
      wr(8'h0D, 16'hBFFF);
      rdc(8'h0D, 16'hBF00);
      wr(8'h0E, 16'hFFFF);
      rdc(8'h0E, 16'h0000);
      @(posedge core_clk);
      wdt_reset <= 1'b1;
      @(posedge core_clk);
      wdt_reset <= 1'b0;
      rdc(8'h0C, 16'h3410);
      rdc(8'h0D, 16'h9F00);
      zone(4, 4'b1000, 16'h41A0, 16'h07D0);
      wr(8'h0D, 16'hBF00);
      zone(4, 4'b1100, 16'h41A0, 16'h07D0);
      zone(2, 4'b1000, 16'h41A0, 16'h07D0);
      zone(3, 4'b1000, 16'h41A0, 16'h07D0);
      for (int c = 0; c < 4; c++) begin
         wr(8'h0C, 16'(c << 13 | (3 - c) << 11 | 16'h07C0 | c << 4));
         cell_count <= 2'(c);
         zone(0, {2'h2, c[0], c[1]}, tv(c, c), tc(c, c));
         zone(1, {2'h2, ~c[0], ~c[1]}, tv(3 - c, c), tc(3 - c, c));
      end
      wr(8'h0D, 16'h3F00);
      zone(4, 4'b0000, 16'h41A0, 16'h07D0);
      wr(8'h0D, 16'hBE00);
      zone(0, 4'b1000, 16'h41A0, 16'h07D0);
      wr(8'h0D, 16'hBC00);
      zone(0, 4'b0000, 16'h41A0, 16'h07D0);
      wr(8'h0D, 16'hBF00);
      wr(8'h0C, 16'h27C0);
      battery_full_voltage <= 16'h03E8;
      zone(0, 4'b1010, 16'h0000, 16'h07D0);
      finish_test();
   end
endmodule
